// [core/occ_consts.svh]
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OCC_ADDR_CTRL 12'h000
`define OCC_ADDR_CMP 12'h004
`define OCC_ADDR_CNT 12'h008
`define OCC_ADDR_LSB 2
`define OCC_ADDR_W 12

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define OCC_CTRL_W 16
`define OCC_CTRL_RSVD_HI 15
`define OCC_CTRL_RSVD_LO 14
`define OCC_BIT_IDLE_STOP 13
`define OCC_TSEL_HI 12
`define OCC_TSEL_LO 10
`define OCC_BIT_CMP_FLT_EN 9
`define OCC_BIT_PINB_FLT_EN 8
`define OCC_BIT_PINA_FLT_EN 7
`define OCC_BIT_CMP_FLT_ST 6
`define OCC_BIT_PINB_FLT_ST 5
`define OCC_BIT_PINA_FLT_ST 4
`define OCC_BIT_TRIG 3
`define OCC_MODE_HI 2
`define OCC_MODE_LO 0

// ----------------------------------------
// Time base codes
// ----------------------------------------
`define OCC_TSEL_PERIPH 3'h7
`define OCC_TSEL_RSVD6 3'h6
`define OCC_TSEL_RSVD5 3'h5
`define OCC_TSEL_T1 3'h4
`define OCC_TSEL_T5 3'h3
`define OCC_TSEL_T4 3'h2
`define OCC_TSEL_T3 3'h1
`define OCC_TSEL_T2 3'h0

// ----------------------------------------
// Mode codes and reset values
// ----------------------------------------
`define OCC_MODE_OFF 3'h0
`define OCC_MODE_FLT_A 3'h6
`define OCC_MODE_FLT_B 3'h7
`define OCC_CTRL_RST 16'h0000
`define OCC_CMP_RST 16'h0000
`define OCC_CNT_RST 16'h0000
`define OCC_CNT_ONE 16'h0001
`define OCC_DATA_ZERO 32'h0000_0000

`endif

// [core/occ_pkg.sv]
package occ_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} occ_apb_req_type;

	typedef struct packed {
		logic periph;
		logic t1;
		logic t2;
		logic t3;
		logic t4;
		logic t5;
	} occ_ticks_type;

	typedef struct packed {
		logic cmp1;
		logic cmp2;
		logic cmp3;
	} occ_comparators_type;

	typedef struct packed {
		logic status;
	} occ_latch_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic idle_stop_select;
		logic [2:0] time_base_select;
		logic comparator_fault_enable;
		logic pin_b_fault_enable;
		logic pin_a_fault_enable;
		logic trigger_behaviour_select;
		logic [2:0] compare_mode_field;
		logic [15:0] compare_value;
		logic [15:0] count;
		logic pin;
	} occ_state_type;

endpackage

// [core/occ_fault_latch.sv]
`timescale 1ns/1ps
`default_nettype none

module occ_fault_latch (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fault source
	input wire logic fault_in,
	input wire logic enable,
	input wire logic mode_valid,
	// Software access
	input wire logic sw_we,
	input wire logic sw_wdata,
	// Status
	output logic status
);

	occ_pkg::occ_latch_type st_ff;
	occ_pkg::occ_latch_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (sw_we) begin
			nxt_st.status = sw_wdata;
		end
		// Hardware clears once the mode leaves the fault modes
		if (!mode_valid) begin
			nxt_st.status = 1'b0;
		end
		// Set wins over a software clear in the same cycle
		if (fault_in && enable && mode_valid) begin
			nxt_st.status = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign status = st_ff.status;

endmodule // occ_fault_latch

`default_nettype wire

// [core/occ_top.sv]
// Contract
// - Control bits 15-14 always read zero.
// - Idle-stop bit halts channel during CPU idle.
// - Time-base select picks peripheral or timer clock.
// - Timer1 base only with synchronous timer clocking.
// - Bit 9 enables comparator fault source.
// - Bit 8 enables fault pin B.
// - Bit 7 enables fault pin A.
// - Bit 6 set by comparator fault.
// - Bit 5 set by pin B fault.
// - Fault bits act only in modes 110/111.
// - Comparator shared per channel pair.
// - All control bits reset to zero.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "occ_consts.svh"

module occ_top #(
	parameter int CHANNEL = 1
) (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB request
	input wire occ_pkg::occ_apb_req_type apb_req,
	// APB answer
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Time bases
	input wire occ_pkg::occ_ticks_type ticks,
	input wire logic timer1_sync_mode,
	// CPU power state
	input wire logic cpu_idle,
	// Fault sources
	input wire logic fault_pin_a,
	input wire logic fault_pin_b,
	input wire occ_pkg::occ_comparators_type comparators,
	// Channel output
	output logic compare_output_pin,
	output logic trigger_behaviour_select
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	occ_pkg::occ_state_type s_ff;
	occ_pkg::occ_state_type nxt_s;

	logic setup_phase;
	logic access_phase;
	logic wr_ctrl;
	logic wr_cmp;
	logic mapped;
	logic mode_valid;
	logic comparator_fault;
	logic base_tick;
	logic running;
	logic fault_active;
	logic comparator_fault_status;
	logic pin_b_fault_status;
	logic pin_a_fault_status;
	logic [15:0] ctrl_read;
	logic sel_ctrl;
	logic sel_cmp;
	logic sel_cnt;
	logic [31:0] rd_word;
	logic [2:0] fault_status;
	logic count_clear;
	logic count_step;
	logic pin_level;
	logic wr_idle_stop;
	logic [2:0] wr_tsel;
	logic wr_cmp_en;
	logic wr_pinb_en;
	logic wr_pina_en;
	logic wr_cmp_st;
	logic wr_pinb_st;
	logic wr_pina_st;
	logic wr_trig;
	logic [2:0] wr_mode;
	logic [15:0] wr_value;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign sel_ctrl = (apb_req.paddr == `OCC_ADDR_CTRL);
	assign sel_cmp = (apb_req.paddr == `OCC_ADDR_CMP);
	assign sel_cnt = (apb_req.paddr == `OCC_ADDR_CNT);
	assign setup_phase = apb_req.psel && !apb_req.penable;
	// Access qualified by our own ready, so a stray penable writes nothing
	assign access_phase = apb_req.psel && apb_req.penable && s_ff.pready;
	assign mapped = sel_ctrl || sel_cmp || sel_cnt;
	assign wr_ctrl = access_phase && apb_req.pwrite && sel_ctrl;
	assign wr_cmp = access_phase && apb_req.pwrite && sel_cmp;

	// ----------------------------------------
	// Write data fields
	// ----------------------------------------
	assign wr_idle_stop = apb_req.pwdata[`OCC_BIT_IDLE_STOP];
	assign wr_tsel = apb_req.pwdata[`OCC_TSEL_HI:`OCC_TSEL_LO];
	assign wr_cmp_en = apb_req.pwdata[`OCC_BIT_CMP_FLT_EN];
	assign wr_pinb_en = apb_req.pwdata[`OCC_BIT_PINB_FLT_EN];
	assign wr_pina_en = apb_req.pwdata[`OCC_BIT_PINA_FLT_EN];
	assign wr_cmp_st = apb_req.pwdata[`OCC_BIT_CMP_FLT_ST];
	assign wr_pinb_st = apb_req.pwdata[`OCC_BIT_PINB_FLT_ST];
	assign wr_pina_st = apb_req.pwdata[`OCC_BIT_PINA_FLT_ST];
	assign wr_trig = apb_req.pwdata[`OCC_BIT_TRIG];
	assign wr_mode = apb_req.pwdata[`OCC_MODE_HI:`OCC_MODE_LO];
	// Upper half of the bus word is ignored on writes
	assign wr_value = apb_req.pwdata[`OCC_CTRL_W-1:0];

	// ----------------------------------------
	// Read data select
	// ----------------------------------------
	// Upper half of every word reads zero
	always_comb begin
		rd_word = `OCC_DATA_ZERO;
		if (sel_ctrl) begin
			rd_word = {16'h0000, ctrl_read};
		end else if (sel_cmp) begin
			rd_word = {16'h0000, s_ff.compare_value};
		end else if (sel_cnt) begin
			rd_word = {16'h0000, s_ff.count};
		end
	end

	// ----------------------------------------
	// Fault qualification
	// ----------------------------------------
	// fault modes only
	assign mode_valid = (s_ff.compare_mode_field == `OCC_MODE_FLT_A)
		|| (s_ff.compare_mode_field == `OCC_MODE_FLT_B);

	always_comb begin
		if (CHANNEL <= 2) begin
			comparator_fault = comparators.cmp1;
		end else if (CHANNEL <= 4) begin
			comparator_fault = comparators.cmp2;
		end else begin
			comparator_fault = comparators.cmp3;
		end
	end

	// ----------------------------------------
	// Fault latches
	// ----------------------------------------
	// comparator fault status
	occ_fault_latch u_cmp_latch (
		.pclk(pclk),
		.presetn(presetn),
		.fault_in(comparator_fault),
		.enable(s_ff.comparator_fault_enable),
		.mode_valid(mode_valid),
		.sw_we(wr_ctrl),
		.sw_wdata(wr_cmp_st),
		.status(comparator_fault_status)
	);

	occ_fault_latch u_pinb_latch (
		.pclk(pclk),
		.presetn(presetn),
		.fault_in(fault_pin_b),
		.enable(s_ff.pin_b_fault_enable),
		.mode_valid(mode_valid),
		.sw_we(wr_ctrl),
		.sw_wdata(wr_pinb_st),
		.status(pin_b_fault_status)
	);

	occ_fault_latch u_pina_latch (
		.pclk(pclk),
		.presetn(presetn),
		.fault_in(fault_pin_a),
		.enable(s_ff.pin_a_fault_enable),
		.mode_valid(mode_valid),
		.sw_we(wr_ctrl),
		.sw_wdata(wr_pina_st),
		.status(pin_a_fault_status)
	);

	// Latched fault holds the pin low until software clears it or the mode leaves the fault modes
	assign fault_status = {comparator_fault_status, pin_b_fault_status, pin_a_fault_status};
	assign fault_active = mode_valid && (|fault_status);

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	// time base select
	always_comb begin
		unique case (s_ff.time_base_select)
			`OCC_TSEL_PERIPH: base_tick = ticks.periph;
			`OCC_TSEL_T1: base_tick = ticks.t1 && timer1_sync_mode;
			`OCC_TSEL_T5: base_tick = ticks.t5;
			`OCC_TSEL_T4: base_tick = ticks.t4;
			`OCC_TSEL_T3: base_tick = ticks.t3;
			`OCC_TSEL_T2: base_tick = ticks.t2;
			// Reserved codes give no time base
			default: base_tick = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Idle control
	// ----------------------------------------
	// Halting freezes the count; a latched fault still forces the pin low
	// halt in idle
	assign running = (s_ff.compare_mode_field != `OCC_MODE_OFF)
		&& !(cpu_idle && s_ff.idle_stop_select);

	// ----------------------------------------
	// Counter and pin
	// ----------------------------------------
	// Counter freezes while halted, restarts from zero when off
	assign count_clear = (s_ff.compare_mode_field == `OCC_MODE_OFF);
	assign count_step = running && base_tick;
	// Fault forces low; a held fault outlasts the compare match
	assign pin_level = !count_clear && !fault_active && (s_ff.count < s_ff.compare_value);

	// ----------------------------------------
	// Control register read view
	// ----------------------------------------
	// top bits read zero
	assign ctrl_read = {
		2'h0,
		s_ff.idle_stop_select,
		s_ff.time_base_select,
		s_ff.comparator_fault_enable,
		s_ff.pin_b_fault_enable,
		s_ff.pin_a_fault_enable,
		comparator_fault_status,
		pin_b_fault_status,
		pin_a_fault_status,
		s_ff.trigger_behaviour_select,
		s_ff.compare_mode_field
	};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		// One wait-free access cycle: answer prepared in setup
		nxt_s.pready = 1'b0;
		nxt_s.pslverr = 1'b0;
		nxt_s.prdata = `OCC_DATA_ZERO;
		if (setup_phase) begin
			nxt_s.pready = 1'b1;
			nxt_s.pslverr = !mapped;
			if (!apb_req.pwrite) begin
				nxt_s.prdata = rd_word;
			end
		end
		if (wr_ctrl) begin
			nxt_s.idle_stop_select = wr_idle_stop;
			nxt_s.time_base_select = wr_tsel;
			nxt_s.comparator_fault_enable = wr_cmp_en;
			nxt_s.pin_b_fault_enable = wr_pinb_en;
			nxt_s.pin_a_fault_enable = wr_pina_en;
			nxt_s.trigger_behaviour_select = wr_trig;
			nxt_s.compare_mode_field = wr_mode;
		end
		if (wr_cmp) begin
			nxt_s.compare_value = wr_value;
		end
		// Count wraps from all ones to zero
		if (count_clear) begin
			nxt_s.count = `OCC_CNT_RST;
		end else if (count_step) begin
			nxt_s.count = s_ff.count + `OCC_CNT_ONE;
		end
		// Pin: high while count below compare
		nxt_s.pin = pin_level;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// reset to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output is a flop of the state struct
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign prdata = s_ff.prdata;
	assign compare_output_pin = s_ff.pin;
	assign trigger_behaviour_select = s_ff.trigger_behaviour_select;

endmodule // occ_top

`default_nettype wire

// [sim/occ_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// --
// Port checks
// --
module occ_chk (
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire occ_pkg::occ_apb_req_type apb_req,
	input wire logic pready,
	input wire logic [31:0] prdata,
	// Pins
	input wire logic fault_pin_a,
	input wire logic fault_pin_b,
	input wire occ_pkg::occ_comparators_type comparators,
	input wire logic compare_output_pin,
	input wire logic trigger_behaviour_select
);
	logic [15:0] ctl_ff;
	logic rd_ctl;
	logic wr_ctl;
	logic on;
	assign rd_ctl = pready & !apb_req.pwrite & (apb_req.paddr == 12'h000);
	assign wr_ctl = pready & apb_req.pwrite & (apb_req.paddr == 12'h000);
	assign on = ctl_ff[2:1] == 2'h3;
	// Shadow of the control word, so faults can be judged at the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ctl_ff <= 16'h0000;
		else if (wr_ctl) ctl_ff <= apb_req.pwdata[15:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rsvd; rd_ctl |-> prdata[31:14] == 18'h00000; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits high");
	property p_rdbk;
		rd_ctl |-> prdata[13:7] == ctl_ff[13:7] && prdata[3:0] == ctl_ff[3:0];
	endproperty
	a_rdbk: assert property (p_rdbk) else $error("control readback");
	property p_ack; apb_req.psel && !apb_req.penable |=> pready ##1 !pready; endproperty
	a_ack: assert property (p_ack) else $error("ready timing");
	property p_trig; trigger_behaviour_select == ctl_ff[3]; endproperty
	a_trig: assert property (p_trig) else $error("trigger mirror");
	property p_off; ctl_ff[2:0] == 3'h0 [*2] |-> !compare_output_pin; endproperty
	a_off: assert property (p_off) else $error("pin high when off");
	property p_fa; ctl_ff[7] && on && fault_pin_a |-> ##2 !compare_output_pin; endproperty
	a_fa: assert property (p_fa) else $error("pin A fault");
	property p_fb; ctl_ff[8] && on && fault_pin_b |-> ##2 !compare_output_pin; endproperty
	a_fb: assert property (p_fb) else $error("pin B fault");
	property p_fc; ctl_ff[9] && on && comparators.cmp1 |-> ##2 !compare_output_pin; endproperty
	a_fc: assert property (p_fc) else $error("comparator fault");
	c_fc: cover property (ctl_ff[9] && on && comparators.cmp1);
	c_t1: cover property (ctl_ff[12:10] == 3'h4 && ctl_ff[2:0] == 3'h1);
	c_rd: cover property (rd_ctl);
endmodule // occ_chk
bind occ_top occ_chk u_chk (.pclk, .presetn, .apb_req, .pready, .prdata, .fault_pin_a,
	.fault_pin_b, .comparators, .compare_output_pin, .trigger_behaviour_select);
`default_nettype wire

// [sim/occ_far.sv]
`timescale 1ns/1ps
`default_nettype none
// --
// Timers, comparators, fault pins
// --
module occ_far (
	// Clock and bench requests
	input wire logic pclk,
	input wire logic [5:0] tick_mask,
	input wire logic [4:0] flt_req,
	// Far side lines
	output var occ_pkg::occ_ticks_type ticks,
	output var occ_pkg::occ_comparators_type comparators,
	output logic fault_pin_a,
	output logic fault_pin_b
);
	logic ph_ff = 1'b0;
	// Pulse every second cycle, so a stuck level is not taken for ticks
	always_ff @(posedge pclk) begin
		ph_ff <= !ph_ff;
	end
	assign ticks = occ_pkg::occ_ticks_type'(ph_ff ? tick_mask : 6'h00);
	assign {comparators, fault_pin_b, fault_pin_a} = flt_req;
endmodule // occ_far
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// --
// Bench
// --
module tb;
	logic pclk, presetn, pready, pslverr, compare_output_pin, trigger_behaviour_select;
	logic fault_pin_a, fault_pin_b, t1s, idle, err, go;
	logic [31:0] prdata, rd;
	occ_pkg::occ_apb_req_type req;
	occ_pkg::occ_ticks_type ticks;
	occ_pkg::occ_comparators_type comparators;
	logic [5:0] mask;
	logic [4:0] flt;
	logic [15:0] d, v;
	logic [2:0] c;
	int n_errors, num_checks, seed, s, k;
	int cyc = 0;
	// Time base code to the tick line it selects
	logic [5:0] bb [8] = '{6'h08, 6'h04, 6'h02, 6'h01, 6'h10, 6'h00, 6'h00, 6'h20};
	occ_top #(.CHANNEL(1)) u_dut (.pclk, .presetn, .apb_req(req), .pready, .pslverr, .prdata,
		.ticks, .timer1_sync_mode(t1s), .cpu_idle(idle), .fault_pin_a, .fault_pin_b,
		.comparators, .compare_output_pin, .trigger_behaviour_select);
	occ_far u_far (.pclk, .tick_mask(mask), .flt_req(flt), .ticks, .comparators,
		.fault_pin_a, .fault_pin_b);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		req <= '{1'b1, 1'b0, w, a, wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		// Only the bench timeout ends a wait for ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] ctl_exp(input logic [15:0] x, input logic [15:0] p);
		// Status bits survive a write only if old and new modes are fault modes
		return {16'h0000, x & ((x[2:1] == 2'h3 && p[2:1] == 2'h3) ? 16'h3FFF : 16'h3F8F)};
	endfunction
	initial begin
		seed = 79070;
		n_errors = 0;
		num_checks = 0;
		presetn = 1'b0;
		req = '0;
		{mask, flt, t1s, idle} = 13'h0000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 12'(i * 4), 32'h00000000);
			chk("reset", rd, 32'h00000000);
		end
		v = 16'h0000;
		for (int i = 0; i < 12; i++) begin
			d = (i < 2) ? 16'hFFFF : 16'($random(seed));
			apb(1'b1, 12'h000, {16'hFFFF, d});
			apb(1'b0, 12'h000, 32'h00000000);
			chk("ctrl", rd, ctl_exp(d, v));
			v = d;
		end
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		chk("slverr", {31'h0, err}, 32'h00000001);
		apb(1'b0, 12'h00C, 32'h00000000);
		chk("unmapped", rd, 32'h00000000);
		// Compare of one keeps the pin high at count zero, so a fault shows
		apb(1'b1, 12'h004, 32'h00000001);
		for (int i = 0; i < 15; i++) begin
			s = i % 3;
			k = i / 3;
			v = (k == 2) ? 16'h0000 : 16'(16'h0080 << s);
			v = v | ((k == 1) ? 16'h0006 : (k == 3) ? 16'h0005 : 16'h0007);
			apb(1'b1, 12'h000, {16'h0000, v});
			// Channel one sees only the first comparator; k 4 drives the other two
			flt <= (k == 4) ? 5'h0C : (s == 2) ? 5'h10 : 5'(5'h01 << s);
			repeat (3) @(posedge pclk);
			flt <= 5'h00;
			apb(1'b0, 12'h000, 32'h00000000);
			v = v | ((k < 2) ? 16'(16'h0010 << s) : 16'h0000);
			chk("fault", rd, {16'h0000, v});
			chk("fault pin", {31'h0, compare_output_pin}, {31'h0, k >= 2});
		end
		for (int i = 0; i < 16; i++) begin
			c = 3'(i);
			mask <= (i < 8) ? bb[c] : 6'h3F;
			t1s <= (i < 8);
			idle <= 1'b1;
			apb(1'b1, 12'h000, 32'h00000000);
			apb(1'b1, 12'h000, {18'h00000, (i >= 8) && c[0], c, 10'h001});
			repeat (8) @(posedge pclk);
			apb(1'b0, 12'h008, 32'h00000000);
			go = (bb[c] != 6'h00) && (i < 8 || (c != 3'h4 && !c[0]));
			chk("count", {31'h0, rd != 32'h0}, {31'h0, go});
			chk("pin", {31'h0, compare_output_pin}, {31'h0, !go});
		end
		conclude();
	end
endmodule // tb
`default_nettype wire
